/* File: core/nsc_combiner.sv */
// four-port sentence combiner with pass lists, priority and rate limit
`timescale 1ns/100ps
`default_nettype none
module nsc_combiner
  import nsc_pkg::*;
#(
  parameter int unsigned TYPES    = 256,
  parameter int unsigned BYTE_CYC = NSC_BYTE_CYC
)(
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic [NSC_PORTS-1:0]       in_valid,
  output logic      [NSC_PORTS-1:0]       in_ready,
  input  wire logic [NSC_PORTS*8-1:0]     in_data,
  input  wire logic [NSC_PORTS-1:0]       in_first,
  input  wire logic [NSC_PORTS-1:0]       in_last,
  input  wire logic [NSC_PORTS*NSC_TYPE_W-1:0] in_type,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic      [7:0]                 out_data,
  output logic                            out_last,
  output logic      [1:0]                 out_port,
  output logic                            host_valid,
  output logic      [7:0]                 host_data,
  output logic      [1:0]                 host_port,
  output logic                            host_status_tag,
  input  wire logic                       list_wr,
  input  wire logic [1:0]                 list_wr_port,
  input  wire logic [NSC_TYPE_W-1:0]      list_wr_type,
  input  wire logic                       list_wr_en,
  input  wire logic                       list_defaults,
  input  wire logic                       host_detected,
  input  wire logic [1:0]                 list_rd_port,
  input  wire logic [NSC_TYPE_W-1:0]      list_rd_type,
  output logic                            list_rd_en,
  output logic                            list_busy,
  input  wire logic                       cfg_wr,
  input  wire logic [7:0]                 cfg_prio,
  input  wire logic [3:0]                 cfg_baud_hi,
  input  wire logic [7:0]                 cfg_host_baud,
  input  wire logic                       cfg_status_en,
  input  wire logic                       cfg_defaults,
  output logic      [7:0]                 rd_prio,
  output logic      [3:0]                 rd_baud_hi,
  output logic      [7:0]                 rd_host_baud,
  output logic                            rd_status_en,
  output logic      [NSC_PORTS-1:0]       drop_pulse
);
  if (TYPES != (1 << NSC_TYPE_W) || BYTE_CYC < 1)
    $error("nsc_combiner: unsupported parameters");

  // per-port pass lists, one bit per sentence type
  logic [TYPES-1:0] list_q [NSC_PORTS];
  logic [TYPES-1:0] list_d [NSC_PORTS];
  nsc_store_e       st_q, st_d;
  logic [4:0]       ecnt_q, ecnt_d;
  logic [1:0]       lport_q, lport_d;
  logic [NSC_TYPE_W-1:0] ltype_q, ltype_d;
  logic             len_q, len_d;
  logic [7:0]       prio_q, prio_d;
  logic [3:0]       baud_q, baud_d;
  logic [7:0]       hbaud_q, hbaud_d;
  logic             sten_q, sten_d;
  logic [NSC_PORTS-1:0] pass_q, pass_d;
  logic [NSC_PORTS-1:0] busy_q, busy_d;
  logic [1:0]       own_q, own_d;
  logic             lock_q, lock_d;
  logic [31:0]      tick_q, tick_d;
  logic             credit_q, credit_d;
  logic [7:0]       od_q, od_d;
  logic             ol_q, ol_d, ov_q, ov_d;
  logic [1:0]       op_q, op_d;
  logic [7:0]       hd_q, hd_d;
  logic             hv_q, hv_d, ht_q, ht_d;
  logic [1:0]       hp_q, hp_d;

  function automatic logic [1:0] prio_port(input logic [7:0] p, input int unsigned r);
    prio_port = p[r*2 +: 2];
  endfunction

  function automatic logic pass_now(input logic [1:0] p);
    pass_now = busy_q[p] ? pass_q[p] : list_q[p][in_type[p*NSC_TYPE_W +: NSC_TYPE_W]];
  endfunction

  // pass list store: erase phase then program phase
  always_comb
  begin
    st_d    = st_q;
    ecnt_d  = ecnt_q;
    lport_d = lport_q;
    ltype_d = ltype_q;
    len_d   = len_q;
    for (int i = 0; i < NSC_PORTS; i++)
      list_d[i] = list_q[i];
    case (st_q)
      NSC_IDLE:
        if (list_defaults)
        begin
          for (int i = 0; i < NSC_PORTS; i++)
            list_d[i] = '1;
        end
        else if (list_wr && host_detected)
        begin
          lport_d = list_wr_port;
          ltype_d = list_wr_type;
          len_d   = list_wr_en;
          ecnt_d  = 5'(NSC_ERASE_CYC - 1);
          st_d    = NSC_ERASE;
        end
      NSC_ERASE:
        if (ecnt_q == 5'h00)
        begin
          list_d[lport_q][ltype_q] = 1'b1;
          st_d = NSC_PROG;
        end
        else
          ecnt_d = ecnt_q - 5'h01;
      NSC_PROG:
      begin
        list_d[lport_q][ltype_q] = len_q;
        st_d = NSC_IDLE;
      end
      default:
        st_d = NSC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NSC_PORTS; i++)
        list_q[i] <= '1;
      st_q    <= NSC_IDLE;
      ecnt_q  <= 5'h00;
      lport_q <= 2'h0;
      ltype_q <= '0;
      len_q   <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NSC_PORTS; i++)
        list_q[i] <= list_d[i];
      st_q    <= st_d;
      ecnt_q  <= ecnt_d;
      lport_q <= lport_d;
      ltype_q <= ltype_d;
      len_q   <= len_d;
    end
  end

  assign list_rd_en = list_q[list_rd_port][list_rd_type];
  assign list_busy  = (st_q != NSC_IDLE);

  // port configuration, one-cycle update
  always_comb
  begin
    prio_d  = prio_q;
    baud_d  = baud_q;
    hbaud_d = hbaud_q;
    sten_d  = sten_q;
    if (cfg_defaults)
    begin
      prio_d  = NSC_PRIO_RST;
      baud_d  = NSC_BAUD_RST;
      hbaud_d = NSC_HBAUD_RST;
      sten_d  = NSC_STAT_RST;
    end
    else if (cfg_wr && host_detected)
    begin
      prio_d  = cfg_prio;
      baud_d  = cfg_baud_hi;
      hbaud_d = cfg_host_baud;
      sten_d  = cfg_status_en;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prio_q  <= NSC_PRIO_RST;
      baud_q  <= NSC_BAUD_RST;
      hbaud_q <= NSC_HBAUD_RST;
      sten_q  <= NSC_STAT_RST;
    end
    else
    begin
      prio_q  <= prio_d;
      baud_q  <= baud_d;
      hbaud_q <= hbaud_d;
      sten_q  <= sten_d;
    end
  end

  assign rd_prio      = prio_q;
  assign rd_baud_hi   = baud_q;
  assign rd_host_baud = hbaud_q;
  assign rd_status_en = sten_q;

  // winner: highest priority valid port, skipping ports partway through a filtered sentence; a new sentence is not checked against the list
  logic [1:0] win;
  logic       win_ok;
  always_comb
  begin
    win    = 2'h0;
    win_ok = 1'b0;
    for (int r = NSC_PORTS - 1; r >= 0; r--)
      if (in_valid[prio_port(prio_q, r)] && (busy_q[prio_port(prio_q, r)]
          ? pass_q[prio_port(prio_q, r)] : 1'b1))
      begin
        win    = prio_port(prio_q, r);
        win_ok = 1'b1;
      end
  end

  logic [1:0] cur;
  logic       out_take, out_space;
  assign cur       = lock_q ? own_q : win;
  assign out_space = !ov_q || out_ready;
  // one output byte per rate slot; excess waits on the input side
  assign out_take  = credit_q && out_space && in_valid[cur] && pass_now(cur)
                     && (lock_q || win_ok);

  // one byte taken per cycle so the host copy never loses one; filtered ports drain
  always_comb
  begin
    in_ready = '0;
    if (out_take)
      in_ready[cur] = 1'b1;
    else
      for (int i = NSC_PORTS - 1; i >= 0; i--)
        if (in_valid[i] && !pass_now(2'(i)))
        begin
          in_ready    = '0;
          in_ready[i] = 1'b1;
        end
  end

  always_comb
  begin
    pass_d     = pass_q;
    busy_d     = busy_q;
    own_d      = own_q;
    lock_d     = lock_q;
    tick_d     = tick_q;
    credit_d   = credit_q;
    drop_pulse = '0;
    // slot timer restarts at each take, so takes are at least BYTE_CYC + 1 cycles apart
    if (!credit_q)
    begin
      if (tick_q == 32'(BYTE_CYC - 1))
        credit_d = 1'b1;
      else
        tick_d = tick_q + 32'h1;
    end
    for (int i = 0; i < NSC_PORTS; i++)
      if (in_valid[i] && in_ready[i])
      begin
        if (in_first[i])
        begin
          pass_d[i] = list_q[i][in_type[i*NSC_TYPE_W +: NSC_TYPE_W]];
          busy_d[i] = !in_last[i];
          drop_pulse[i] = !pass_d[i];
        end
        else if (in_last[i])
          busy_d[i] = 1'b0;
      end
    if (out_take)
    begin
      credit_d = 1'b0;
      tick_d   = 32'h0;
      own_d    = cur;
      lock_d   = !in_last[cur]; // whole sentences only
    end
  end

  always_comb
  begin
    od_d = od_q;
    ol_d = ol_q;
    op_d = op_q;
    ov_d = ov_q && !out_ready;
    if (out_take)
    begin
      od_d = in_data[cur*8 +: 8];
      ol_d = in_last[cur];
      op_d = cur;
      ov_d = 1'b1;
    end
    hv_d = 1'b0;
    hd_d = hd_q;
    hp_d = hp_q;
    ht_d = 1'b0;
    for (int i = NSC_PORTS - 1; i >= 0; i--)
      if (in_valid[i] && in_ready[i])
      begin
        hv_d = 1'b1;
        hd_d = in_data[i*8 +: 8];
        hp_d = 2'(i);
        ht_d = sten_q && in_first[i];
      end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pass_q <= '0;
      busy_q <= '0;
      own_q <= 2'h0;
      lock_q <= 1'b0;
      tick_q <= 32'h0;
      credit_q <= 1'b1;
      od_q <= 8'h00;
      ol_q <= 1'b0;
      op_q <= 2'h0;
      ov_q <= 1'b0;
      hd_q <= 8'h00;
      hv_q <= 1'b0;
      hp_q <= 2'h0;
      ht_q <= 1'b0;
    end
    else
    begin
      pass_q <= pass_d;
      busy_q <= busy_d;
      own_q <= own_d;
      lock_q <= lock_d;
      tick_q <= tick_d;
      credit_q <= credit_d;
      od_q <= od_d;
      ol_q <= ol_d;
      op_q <= op_d;
      ov_q <= ov_d;
      hd_q <= hd_d;
      hv_q <= hv_d;
      hp_q <= hp_d;
      ht_q <= ht_d;
    end
  end

  assign out_valid       = ov_q;
  assign out_data        = od_q;
  assign out_last        = ol_q;
  assign out_port        = op_q;
  assign host_valid      = hv_q;
  assign host_data       = hd_q;
  assign host_port       = hp_q;
  assign host_status_tag = ht_q;

  AST_LIST_ERASE_THEN_PROG: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_q == NSC_ERASE && ecnt_q == 5'h00 |=> st_q == NSC_PROG ##1 st_q == NSC_IDLE)
    else $error("store did not program after erase");
  AST_LIST_NEEDS_DETECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_q == NSC_IDLE && list_wr && !host_detected && !list_defaults |=> st_q == NSC_IDLE)
    else $error("list write started without detection");
  AST_LIST_WRITTEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_q == NSC_PROG |=> list_q[$past(lport_q)][$past(ltype_q)] == $past(len_q))
    else $error("pass list bit not stored");
  AST_CFG_FAST: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_wr && host_detected && !cfg_defaults |=> rd_prio == $past(cfg_prio)
    && rd_status_en == $past(cfg_status_en))
    else $error("configuration not applied");
  AST_CFG_DEFAULT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_defaults |=> rd_prio == NSC_PRIO_RST && rd_baud_hi == NSC_BAUD_RST && rd_status_en)
    else $error("defaults not restored");
  AST_FILTER_DROPS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    out_take |-> pass_now(cur))
    else $error("filtered sentence forwarded");
  AST_HOST_COPY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    |(in_valid & in_ready) |=> host_valid)
    else $error("host copy missed a byte");
  AST_RATE_LIMIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    out_take && BYTE_CYC > 2 |=> !out_take)
    else $error("output rate exceeded");
  AST_TAG_GATED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    host_status_tag |-> $past(sten_q))
    else $error("status tag while disabled");
endmodule
`default_nettype wire

/* File: core/nsc_pkg.sv */
// constants and types shared by the sentence combiner
package nsc_pkg;
  localparam int unsigned NSC_PORTS       = 4;
  localparam int unsigned NSC_TYPE_W      = 8;
  localparam int unsigned NSC_CLK_HZ      = 100_000_000;
  localparam int unsigned NSC_OUT_BPS     = 480;
  localparam int unsigned NSC_BYTE_CYC    = NSC_CLK_HZ / NSC_OUT_BPS;
  localparam int unsigned NSC_BAUD_LO     = 4800;
  localparam int unsigned NSC_BAUD_HI     = 9600;
  localparam int unsigned NSC_HOST_BAUD   = 38400;
  localparam int unsigned NSC_CFG_MS      = 1000;
  localparam int unsigned NSC_CFG_CYC     = NSC_CLK_HZ / 1000 * NSC_CFG_MS;
  localparam int unsigned NSC_ERASE_CYC   = 16;
  localparam logic [7:0]  NSC_PRIO_RST    = 8'he4;
  localparam logic [3:0]  NSC_BAUD_RST    = 4'h0;
  localparam logic        NSC_STAT_RST    = 1'b1;
  localparam logic [7:0]  NSC_HBAUD_RST   = 8'h03;
  typedef enum logic [2:0]
  {
    NSC_IDLE  = 3'b001,
    NSC_ERASE = 3'b010,
    NSC_PROG  = 3'b100
  } nsc_store_e;
endpackage

/* File: test/nsc_talker.sv */
// instrument model: one framed sentence per start pulse, bytes are kind xor index
`timescale 1ns/100ps
`default_nettype none
module nsc_talker
(
  input  wire logic       ref_clk,
  input  wire logic       start,
  input  wire logic [7:0] len,
  input  wire logic [7:0] kind,
  input  wire logic       ready,
  output logic            valid,
  output logic [7:0]      data,
  output logic            first,
  output logic            last,
  output logic [7:0]      code,
  output logic            busy
);
  int i;
  initial
  begin
    {valid, first, last, busy} = 4'h0;
    data = 8'h00;
    code = 8'h00;
    forever
    begin
      @(posedge ref_clk);
      if (start === 1'b1)
      begin
        #1;
        busy = 1'b1;
        for (i = 0; i < len; i++)
        begin
          valid = 1'b1;
          data = kind ^ 8'(i);
          first = (i == 0);
          last = (i == len - 1);
          code = kind;
          do @(posedge ref_clk); while (ready !== 1'b1);
          #1;
        end
        // released data and code lines show the inverse of the last value; valid, first, last and busy drop to 0
        {valid, first, last, busy} = 4'h0;
        data = ~data;
        code = ~code;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_nsc_combiner.sv */
// self-checking bench for the sentence combiner
`timescale 1ns/100ps
`default_nettype none
module tb_nsc_combiner
  import nsc_pkg::*;
();
  localparam int BC = 4;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  wire  [3:0]  in_valid, in_ready, in_first, in_last, busy, drop_pulse, rd_baud_hi;
  wire  [31:0] in_data, in_type;
  wire  [7:0]  out_data, host_data, rd_prio, rd_host_baud;
  wire  [1:0]  out_port, host_port;
  wire         out_valid, out_last, host_valid, host_status_tag, list_rd_en, list_busy;
  wire         rd_status_en;
  logic [3:0]  start, cfg_baud_hi;
  logic [7:0]  kind [4];
  logic [7:0]  len [4];
  logic [7:0]  list_wr_type, list_rd_type, cfg_prio, cfg_host_baud, prio;
  logic [1:0]  list_wr_port, list_rd_port;
  logic        out_ready, list_wr, list_wr_en, list_defaults, host_detected, cfg_wr;
  logic        cfg_status_en, cfg_defaults;
  int          failures = 0, num_checks = 0, cyc = 0, last_out = -100, drops = 0, tags = 0;
  int          exp_drops = 0, exp_tags = 0, n, rot;
  bit          pass_m [4][256];
  bit          stat_m = 1'b1;
  bit          pv = 1'b0, phs = 1'b0;
  logic [7:0]  exp_out [4][$];
  logic [7:0]  exp_host [4][$];
  logic [1:0]  order [$];

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) #1 out_ready = ($urandom_range(0, 3) != 0);

  nsc_combiner #(.BYTE_CYC(BC)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_first(in_first), .in_last(in_last),
    .in_type(in_type), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_last(out_last), .out_port(out_port), .host_valid(host_valid), .host_data(host_data),
    .host_port(host_port), .host_status_tag(host_status_tag), .list_wr(list_wr),
    .list_wr_port(list_wr_port), .list_wr_type(list_wr_type), .list_wr_en(list_wr_en),
    .list_defaults(list_defaults), .host_detected(host_detected), .list_rd_port(list_rd_port),
    .list_rd_type(list_rd_type), .list_rd_en(list_rd_en), .list_busy(list_busy),
    .cfg_wr(cfg_wr), .cfg_prio(cfg_prio), .cfg_baud_hi(cfg_baud_hi),
    .cfg_host_baud(cfg_host_baud), .cfg_status_en(cfg_status_en), .cfg_defaults(cfg_defaults),
    .rd_prio(rd_prio), .rd_baud_hi(rd_baud_hi), .rd_host_baud(rd_host_baud),
    .rd_status_en(rd_status_en), .drop_pulse(drop_pulse));

  for (genvar g = 0; g < 4; g++)
  begin : g_src
    nsc_talker u_src (.ref_clk(ref_clk), .start(start[g]), .len(len[g]), .kind(kind[g]),
      .ready(in_ready[g]), .valid(in_valid[g]), .data(in_data[8*g+:8]), .first(in_first[g]),
      .last(in_last[g]), .code(in_type[8*g+:8]), .busy(busy[g]));
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    // a new output byte appears when valid rises or right after a handshake
    if (out_valid === 1'b1 && (!pv || phs))
    begin
      chk("out gap", 1, (cyc - last_out) >= BC);
      last_out = cyc;
    end
    pv = (out_valid === 1'b1);
    phs = pv && (out_ready === 1'b1);
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      if (exp_out[out_port].size() == 0)
        chk("out extra", 0, 1);
      else
        chk("out byte", exp_out[out_port].pop_front(), out_data);
      if (out_last === 1'b1)
        order.push_back(out_port);
    end
    if (host_valid === 1'b1)
    begin
      if (exp_host[host_port].size() == 0)
        chk("host extra", 0, 1);
      else
        chk("host byte", exp_host[host_port].pop_front(), host_data);
    end
    if (host_status_tag === 1'b1)
      tags++;
    drops += $countones(drop_pulse);
  end

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  function automatic int pend();
    int p, s;
    s = 0;
    for (p = 0; p < 4; p++)
      s += exp_out[p].size() + exp_host[p].size();
    return s;
  endfunction

  task automatic settle();
    int k;
    for (k = 0; k < 3000 && (busy !== 4'h0 || pend() != 0); k++)
      tick();
    if (k == 3000)
    begin
      failures++;
      complete_run();
    end
  endtask

  task automatic burst(input logic [3:0] m);
    int p, i;
    for (p = 0; p < 4; p++)
    begin
      if (m[p])
      begin
        kind[p] = 8'h10 + 8'($urandom_range(0, 3));
        len[p] = 8'($urandom_range(3, 9));
        exp_drops += !pass_m[p][kind[p]];
        exp_tags += stat_m;
        for (i = 0; i < len[p]; i++)
        begin
          exp_host[p].push_back(kind[p] ^ 8'(i));
          if (pass_m[p][kind[p]])
            exp_out[p].push_back(kind[p] ^ 8'(i));
        end
      end
    end
    start = m;
    tick();
    start = 4'h0;
    settle();
  endtask

  task automatic cfgchk(input logic [7:0] pr, input logic [3:0] bd, input logic [7:0] hb,
                        input logic st);
    chk("prio", pr, rd_prio);
    chk("baud", bd, rd_baud_hi);
    chk("host baud", hb, rd_host_baud);
    chk("status en", st, rd_status_en);
  endtask

  task automatic cfgw(input logic d, input logic [7:0] pr, input logic [3:0] bd,
                      input logic [7:0] hb, input logic st);
    cfg_prio = pr;
    cfg_baud_hi = bd;
    cfg_host_baud = hb;
    cfg_status_en = st;
    cfg_defaults = d;
    cfg_wr = ~d;
    tick();
    cfg_defaults = 1'b0;
    cfg_wr = 1'b0;
    tick();
    stat_m = d ? 1'b1 : st;
    if (d)
      cfgchk(NSC_PRIO_RST, NSC_BAUD_RST, NSC_HBAUD_RST, NSC_STAT_RST);
    else
      cfgchk(pr, bd, hb, st);
  endtask

  task automatic rdl(input logic [1:0] p, input logic [7:0] t, input logic e);
    list_rd_port = p;
    list_rd_type = t;
    #1;
    chk("pass list", e, list_rd_en);
  endtask

  task automatic lw(input logic d, input logic [1:0] p, input logic [7:0] t, input logic e);
    int k;
    list_wr_port = p;
    list_wr_type = t;
    list_wr_en = e;
    list_defaults = d;
    list_wr = ~d;
    tick();
    list_defaults = 1'b0;
    list_wr = 1'b0;
    if (d)
      foreach (pass_m[i, j]) pass_m[i][j] = 1'b1;
    else
      chk("store busy", host_detected, list_busy);
    if (host_detected && !d)
      pass_m[p][t] = e;
    for (k = 0; k < 40 && list_busy !== 1'b0; k++)
      tick();
    chk("store done", 1, k < 40);
  endtask

  initial
  begin
    void'($urandom(26415));
    {start, out_ready, list_wr, list_wr_en, list_defaults, host_detected} = '0;
    {cfg_wr, cfg_defaults, cfg_status_en, cfg_baud_hi, cfg_prio, cfg_host_baud} = '0;
    {list_wr_port, list_wr_type, list_rd_port, list_rd_type} = '0;
    foreach (kind[i]) kind[i] = 8'h00;
    foreach (len[i]) len[i] = 8'h00;
    foreach (pass_m[i, j]) pass_m[i][j] = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    tick();
    cfgchk(NSC_PRIO_RST, NSC_BAUD_RST, NSC_HBAUD_RST, NSC_STAT_RST);
    for (n = 0; n < 8; n++)
      rdl(2'(n), 8'($urandom), 1'b1);
    rot = $urandom_range(1, 3);
    for (n = 0; n < 4; n++)
      prio[2*n+:2] = 2'(n + rot);
    host_detected = 1'b1;
    cfgw(1'b0, prio, 4'($urandom), 8'($urandom), 1'b0);
    host_detected = 1'b0;
    lw(1'b0, 2'd1, 8'h11, 1'b0);
    rdl(2'd1, 8'h11, 1'b1);
    host_detected = 1'b1;
    for (n = 0; n < 4; n++)
      lw(1'b0, 2'(n), 8'h10 + 8'($urandom_range(0, 3)), 1'b0);
    for (n = 0; n < 16; n++)
      rdl(2'(n / 4), 8'h10 + 8'(n % 4), pass_m[n / 4][8'h10 + n % 4]);
    for (n = 0; n < 6; n++)
      burst(4'($urandom_range(1, 15)));
    lw(1'b1, 2'd0, 8'h00, 1'b0);
    rdl(2'd2, 8'($urandom), 1'b1);
    order.delete();
    burst(4'hf);
    chk("sentences", 4, order.size());
    for (n = 0; n < 4 && n < order.size(); n++)
      chk("priority order", prio[2*n+:2], order[n]);
    cfgw(1'b1, 8'($urandom), 4'($urandom), 8'($urandom), 1'b0);
    burst(4'($urandom_range(1, 15)));
    tick();
    chk("drops", exp_drops, drops);
    chk("status tags", exp_tags, tags);
    complete_run();
  end
endmodule
`default_nettype wire
